/* File: bench/adc_sweep_sequencer_bench.sv */
`timescale 1ns/100ps
`include "ass_params.svh"
module adc_sweep_sequencer_bench;
  import ass_pkg::*;
  logic        clk_sys = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, adcStart, convIrq, dmaReq, se, dmaOn = 0;
  logic        extTrig = 1, timerReq = 0, res;
  logic [9:0]  adcData;
  logic [1:0]  adcGroup, scan, pg, mg;
  logic [2:0]  adcChannel;
  logic [4:0]  q[$];
  int          err_total = 0, checked = 0, irqs = 0, cyc = 0, p, n;

  adc_sweep_sequencer DUT (.clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_trigger_in(extTrig), .motor_timer_b2_count(timerReq),
    .adcData(adcData), .adcStart(adcStart), .adcGroup(adcGroup), .adcChannel(adcChannel),
    .convIrq(convIrq), .dmaReq(dmaReq));
  ass_conv_model CONV (.clk_sys(clk_sys), .adcStart(adcStart), .adcGroup(adcGroup),
    .adcChannel(adcChannel), .adcData(adcData));

  always #5 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc++;
    if (adcStart) q.push_back({adcGroup, adcChannel});
    if (convIrq) irqs++;
    if (convIrq || dmaReq) check(dmaReq, convIrq & dmaOn);
    if (cyc == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////
  // one transfer; no fixed latency assumed
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys) penable <= 1;
    // only pready or the run-wide cycle limit ends this wait
    do @(posedge clk_sys); while (!pready);
    rd = prdata;
    se = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk_sys);
  endtask

  task automatic waitq(input int m);
    while (q.size() < m) @(posedge clk_sys);
  endtask

  task automatic fire(input logic src);
    if (src) timerReq <= 1;
    else extTrig <= 0;
    @(posedge clk_sys);
    timerReq <= 0;
    extTrig <= 1;
  endtask

  task automatic stop_idle;
    apb(1, `ASS_OFF_CTRL, 32'h0);
    repeat (2) @(posedge clk_sys);
    q.delete();
    repeat (250) @(posedge clk_sys);
    check(q.size(), 0);
  endtask

  function automatic logic [31:0] expRes(input logic [4:0] gc, input logic r);
    logic [9:0] v;
    v = {gc[4:3], gc[2:0], ~gc[2:0], gc[4:3]};
    return r ? {22'h0, v} : {24'h0, v[9:2]};
  endfunction

  function automatic logic [4:0] prioSlot(input int k, input int w, input logic [1:0] g);
    int c;
    c = (k % (w + 1) < w) ? k % (w + 1) : w + (k / (w + 1)) % (8 - w);
    return {g, 3'(c)};
  endfunction
  ////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(72693));
    repeat (3) @(posedge clk_sys);
    srst <= 0;
    @(posedge clk_sys);
    apb(0, 12'h0fc, 32'h0);
    check(se, 1);
    // priority sweep, results per channel
    scan = 2'($urandom_range(3));
    pg = 2'($urandom_range(3));
    res = 1'($urandom_range(1));
    p = scan + 1;
    n = (p + 1) * (8 - p) + 1;
    apb(1, `ASS_OFF_CFG, {26'h0, pg, scan, 2'h0});
    irqs = 0;
    q.delete();
    apb(1, `ASS_OFF_CTRL, {27'h0, res, 4'h1});
    waitq(n);
    // order is checked before stop_idle empties the queue
    for (int k = 0; k < n; k++) check(q[k], prioSlot(k, p, pg));
    stop_idle();
    check(irqs, 0);
    for (int j = 0; j < 8; j++) begin
      apb(0, `ASS_OFF_RES_BASE + 12'(4 * j), 32'h0);
      check(rd, expRes({pg, 3'(j)}, res));
    end
    $display("priority sweep test done");
    // multiport single then repeat
    dmaOn = 1;
    for (int md = 1; md <= 2; md++) begin
      mg = 2'($urandom_range(2));
      res = 1'($urandom_range(1));
      n = (md == 1) ? 16 : 20;
      apb(1, `ASS_OFF_CFG, {24'h0, mg, 4'h0, 2'(md)});
      irqs = 0;
      q.delete();
      apb(1, `ASS_OFF_CTRL, {27'h0, res, 4'h9});
      waitq(n);
      if (md == 1) begin
        repeat (150) @(posedge clk_sys);
        apb(0, `ASS_OFF_CTRL, 32'h0);
        check(rd[0], 0);
        check(q.size(), 16);
        check(irqs, 16);
        apb(0, `ASS_OFF_RES_BASE, 32'h0);
        check(rd, expRes({2'(mg + 1), 3'h7}, res));
      end
      for (int k = 0; k < n; k++)
        check(q[k], (k % 16 < 8) ? {2'h0, 3'(k)} : {2'(mg + 1), 3'(k)});
      if (md == 2) stop_idle();
      $display("multiport test done");
    end
    // external edge and timer request, then retrigger
    apb(1, `ASS_OFF_CFG, 32'h2);
    for (int src = 0; src < 2; src++) begin
      q.delete();
      apb(1, `ASS_OFF_CTRL, 32'h0b | (src << 2));
      repeat (40) @(posedge clk_sys);
      check(q.size(), 0);
      fire(1'(src));
      waitq(1);
      check(q[0], 0);
      waitq(3);
      repeat (40) @(posedge clk_sys);
      n = q.size();
      fire(1'(src));
      waitq(n + 1);
      check(q[n], 0);
      stop_idle();
      $display("trigger test done");
    end
    tally_and_finish();
  end
endmodule // adc_sweep_sequencer_bench

/* File: bench/ass_conv_model.sv */
`timescale 1ns/100ps
module ass_conv_model (
  input  wire logic       clk_sys,
  input  wire logic       adcStart,
  input  wire logic [1:0] adcGroup,
  input  wire logic [2:0] adcChannel,
  output logic      [9:0] adcData
);
  int holdCnt;
  initial begin
    adcData = 10'h000;
    holdCnt = 0;
  end
  ////////////////////////////////////////////////////////////
  // result held past the sample point, then scrambled so a late sample shows
  always @(posedge clk_sys) begin
    if (adcStart) begin
      adcData <= {adcGroup, adcChannel, ~adcChannel, adcGroup};
      holdCnt <= 104;
    end else if (holdCnt > 0) begin
      holdCnt <= holdCnt - 1;
    end else begin
      adcData <= ~adcData;
    end
  end
endmodule // ass_conv_model

/* File: core/adc_sweep_sequencer.sv */
`timescale 1ns/100ps
`include "ass_params.svh"
module adc_sweep_sequencer
  import ass_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ext_trigger_in,
  input  wire logic        motor_timer_b2_count,
  input  wire logic [9:0]  adcData,
  output logic             adcStart,
  output logic [1:0]       adcGroup,
  output logic [2:0]       adcChannel,
  output logic             convIrq,
  output logic             dmaReq
);
  import ass_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic [7:0]  ctrl;
  logic [7:0]  cfg;
  logic [9:0]  channel_result_reg [8];
  ass_state_t  state;
  logic [3:0]  pos;
  logic [1:0]  prioIdx;
  logic        inPrio;
  logic [2:0]  curCh;
  logic [1:0]  curGrp;
  logic        trigPulse;
  logic        convDone;
  logic        startConv;
  logic        abortConv;

  logic [7:0]  next_ctrl;
  ass_state_t  next_state;
  logic [3:0]  next_pos;
  logic [1:0]  next_prioIdx;
  logic        next_inPrio;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic        next_adcStart;
  logic [1:0]  next_adcGroup;
  logic [2:0]  next_adcChannel;
  logic        next_convIrq;
  logic        next_dmaReq;
  logic [9:0]  resVal;
  logic [2:0]  nxtCh;
  logic        nxtBase;
  logic        seqEnd;
  logic [3:0]  firstPos;

  ass_mode_t   mode;
  logic [1:0]  scanW;
  logic [1:0]  pgrp;
  logic [1:0]  mpgrp;
  logic        wrEn;
  logic        rdEn;

  assign mode  = ass_mode_t'(cfg[`ASS_CFG_MODE_LO +: 2]);
  assign scanW = cfg[`ASS_CFG_SCAN_LO +: 2];
  assign pgrp  = cfg[`ASS_CFG_PGRP_LO +: 2];
  assign mpgrp = cfg[`ASS_CFG_MPGRP_LO +: 2];
  assign wrEn  = psel & penable & pwrite & ~pready;
  assign rdEn  = psel & ~penable & ~pwrite;
  // priority sweeps open on channel 0; pos starts at the first channel outside the priority set
  assign firstPos = (mode == ASS_MODE_PRIO) ? {1'b0, 3'(scanW) + 3'h1} : 4'h0;

  ////////////////////////////////////////////////////////////////////////
  ass_trig_detect u_trig (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .extTrigIn (ext_trigger_in),
    .timerIrq  (motor_timer_b2_count),
    .trgSrc    (ctrl[`ASS_CTRL_TRGSRC]),
    .trigPulse (trigPulse)
  );

  ass_conv_timer u_timer (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .startConv (startConv),
    .abortConv (abortConv),
    .convDone  (convDone)
  );

  ////////////////////////////////////////////////////////////////////////
  // channel walk: pos counts non-priority steps, inPrio marks a burst
  always_comb begin
    next_state   = state;
    next_pos     = pos;
    next_prioIdx = prioIdx;
    next_inPrio  = inPrio;
    startConv    = 1'b0;
    abortConv    = 1'b0;
    seqEnd       = 1'b0;
    nxtCh        = 3'h0;
    nxtBase      = 1'b0;
    next_ctrl    = ctrl;
    if (wrEn && paddr == `ASS_OFF_CTRL) begin
      next_ctrl = pwdata[7:0];
    end
    case (state)
      ASS_IDLE: begin
        if (ctrl[`ASS_CTRL_START]) begin
          next_pos     = firstPos;
          next_prioIdx = 2'h0;
          next_inPrio  = (mode == ASS_MODE_PRIO);
          if (!ctrl[`ASS_CTRL_TRGSEL]) begin
            next_state = ASS_CONV;
            startConv  = 1'b1;
          end else begin
            next_state = ASS_ARM;
          end
        end
      end
      ASS_ARM: begin
        if (trigPulse) begin
          next_state = ASS_CONV;
          startConv  = 1'b1;
        end
      end
      ASS_CONV: begin
        if (ctrl[`ASS_CTRL_TRGSEL] && trigPulse) begin
          abortConv    = 1'b1;
          startConv    = 1'b1;
          next_pos     = firstPos;
          next_prioIdx = 2'h0;
          next_inPrio  = (mode == ASS_MODE_PRIO);
        end else if (convDone) begin
          if (mode == ASS_MODE_PRIO) begin
            if (inPrio && prioIdx != scanW) begin
              next_prioIdx = prioIdx + 2'h1;
            end else if (inPrio) begin
              // pos already names the next other channel, so the rotation goes on
              next_inPrio = 1'b0;
            end else begin
              next_inPrio  = 1'b1;
              next_prioIdx = 2'h0;
              next_pos     = (pos[2:0] == 3'h7) ? firstPos : pos + 4'h1;
            end
            startConv = 1'b1;
          end else begin
            next_pos = pos + 4'h1;
            if (pos == 4'hf) begin
              seqEnd = 1'b1;
            end
            if (seqEnd && mode == ASS_MODE_MSING) begin
              next_state = ctrl[`ASS_CTRL_TRGSEL] ? ASS_ARM : ASS_IDLE;
              if (!ctrl[`ASS_CTRL_TRGSEL]) begin
                next_ctrl[`ASS_CTRL_START] = 1'b0;
              end
            end else begin
              startConv = 1'b1;
            end
          end
        end
      end
      default: next_state = ASS_IDLE;
    endcase
    if (!next_ctrl[`ASS_CTRL_START]) begin
      next_state = ASS_IDLE;
      abortConv  = 1'b1;
      startConv  = 1'b0;
    end
    if (next_inPrio && mode == ASS_MODE_PRIO) begin
      nxtCh = 3'(next_prioIdx);
    end else begin
      nxtCh = next_pos[2:0];
    end
    nxtBase = (mode != ASS_MODE_PRIO) && !next_pos[3];
  end

  ////////////////////////////////////////////////////////////////////////
  // result width
  assign resVal = ctrl[`ASS_CTRL_RES10] ? adcData : {2'b00, adcData[9:2]};

  always_comb begin
    next_adcStart   = startConv;
    next_adcChannel = startConv ? nxtCh : adcChannel;
    next_adcGroup   = adcGroup;
    if (startConv) begin
      next_adcGroup = (mode == ASS_MODE_PRIO) ? pgrp : (nxtBase ? 2'h0 : mpgrp + 2'h1);
    end
    next_convIrq = convDone & ctrl[`ASS_CTRL_DMA];
    next_dmaReq  = convDone & ctrl[`ASS_CTRL_DMA];
    next_pready  = psel & penable & ~pready;
    next_pslverr = 1'b0;
    next_prdata  = prdata;
    if (rdEn) begin
      next_prdata = 32'h0000_0000;
      if (paddr == `ASS_OFF_CTRL) begin
        next_prdata = {24'h000000, ctrl};
      end else if (paddr == `ASS_OFF_CFG) begin
        next_prdata = {24'h000000, cfg};
      end else if (paddr == `ASS_OFF_STATUS) begin
        next_prdata = {22'h000000, curGrp, curCh, state, inPrio, 1'b0};
      end else if (paddr[11:5] == 7'h01 && paddr[1:0] == 2'h0) begin
        next_prdata = {22'h000000, channel_result_reg[paddr[4:2]]};
      end
    end
    if (psel && penable && !pready) begin
      next_pslverr = !(paddr == `ASS_OFF_CTRL || paddr == `ASS_OFF_CFG || paddr == `ASS_OFF_STATUS
                       || paddr[11:5] == 7'h01) || paddr[1:0] != 2'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctrl       <= `ASS_CTRL_RST;
      cfg        <= `ASS_CFG_RST;
      state      <= ASS_IDLE;
      pos        <= 4'h0;
      prioIdx    <= 2'h0;
      inPrio     <= 1'b0;
      curCh      <= 3'h0;
      curGrp     <= 2'h0;
      prdata     <= 32'h0000_0000;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      adcStart   <= 1'b0;
      adcGroup   <= 2'h0;
      adcChannel <= 3'h0;
      convIrq    <= 1'b0;
      dmaReq     <= 1'b0;
    end else begin
      ctrl       <= next_ctrl;
      if (wrEn && paddr == `ASS_OFF_CFG) begin
        cfg <= pwdata[7:0];
      end
      state      <= next_state;
      pos        <= next_pos;
      prioIdx    <= next_prioIdx;
      inPrio     <= next_inPrio;
      if (startConv) begin
        curCh  <= next_adcChannel;
        curGrp <= next_adcGroup;
      end
      prdata     <= next_prdata;
      pready     <= next_pready;
      pslverr    <= next_pslverr;
      adcStart   <= next_adcStart;
      adcGroup   <= next_adcGroup;
      adcChannel <= next_adcChannel;
      convIrq    <= next_convIrq;
      dmaReq     <= next_dmaReq;
    end
  end

  for (genvar i = 0; i < 8; i++) begin : g_res
    always_ff @(posedge clk_sys) begin
      if (srst) begin
        channel_result_reg[i] <= 10'h000;
      end else if (convDone && (ctrl[`ASS_CTRL_DMA] ? (i == 0) : (curCh == 3'(i)))) begin
        channel_result_reg[i] <= resVal;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  AST_NO_IRQ_PRIO: assert property (@(posedge clk_sys) disable iff (srst)
    (mode == ASS_MODE_PRIO && !ctrl[`ASS_CTRL_DMA] && !$past(ctrl[`ASS_CTRL_DMA])) |-> !convIrq)
    else $error("interrupt in priority mode without dma");
  AST_IRQ_DMA: assert property (@(posedge clk_sys) disable iff (srst)
    (convDone && ctrl[`ASS_CTRL_DMA]) |=> convIrq && dmaReq)
    else $error("missing request after conversion");
  AST_IRQ_PULSE: assert property (@(posedge clk_sys) disable iff (srst)
    convIrq |=> !convIrq || $past(convDone))
    else $error("interrupt not a pulse");
  AST_SW_START: assert property (@(posedge clk_sys) disable iff (srst)
    (state == ASS_IDLE && ctrl[`ASS_CTRL_START] && !ctrl[`ASS_CTRL_TRGSEL] && next_ctrl[`ASS_CTRL_START])
      |=> adcStart)
    else $error("software start missed");
  AST_ARM_WAIT: assert property (@(posedge clk_sys) disable iff (srst)
    (state == ASS_ARM && !trigPulse) |=> !adcStart)
    else $error("started without trigger");
  AST_STOP: assert property (@(posedge clk_sys) disable iff (srst)
    !ctrl[`ASS_CTRL_START] |-> state == ASS_IDLE || $past(ctrl[`ASS_CTRL_START]))
    else $error("running with start bit clear");
  AST_PRIO_RANGE: assert property (@(posedge clk_sys) disable iff (srst)
    (adcStart && mode == ASS_MODE_PRIO && inPrio) |-> adcChannel <= 3'(scanW))
    else $error("priority channel out of range");
  AST_MP_GROUP: assert property (@(posedge clk_sys) disable iff (srst)
    (adcStart && mode != ASS_MODE_PRIO && pos[3]) |-> adcGroup != 2'h0)
    else $error("second half on base group");
  AST_RES8: assert property (@(posedge clk_sys) disable iff (srst)
    (convDone && !ctrl[`ASS_CTRL_RES10] && ctrl[`ASS_CTRL_DMA]) |=> channel_result_reg[0][9:8] == 2'b00)
    else $error("8-bit result too wide");
  AST_PRIO_OTHER: assert property (@(posedge clk_sys) disable iff (srst)
    (adcStart && mode == ASS_MODE_PRIO && !inPrio) |-> adcChannel > 3'(scanW))
    else $error("other channel inside priority set");
  AST_MP_BASE: assert property (@(posedge clk_sys) disable iff (srst)
    (adcStart && mode != ASS_MODE_PRIO && !pos[3]) |-> adcGroup == 2'h0)
    else $error("first half off the base group");
  AST_SINGLE_END: assert property (@(posedge clk_sys) disable iff (srst)
    (seqEnd && mode == ASS_MODE_MSING && !ctrl[`ASS_CTRL_TRGSEL]) |=> !ctrl[`ASS_CTRL_START])
    else $error("single sweep kept running");
  COV_SW: cover property (@(posedge clk_sys) disable iff (srst) state == ASS_IDLE ##1 state == ASS_CONV);
  COV_RETRIG: cover property (@(posedge clk_sys) disable iff (srst) state == ASS_CONV && trigPulse);
  COV_MSING_END: cover property (@(posedge clk_sys) disable iff (srst) seqEnd && mode == ASS_MODE_MSING);
  COV_PRIO_WRAP: cover property (@(posedge clk_sys) disable iff (srst)
    adcStart && mode == ASS_MODE_PRIO && !inPrio && adcChannel == 3'h7);
  COV_ARMED: cover property (@(posedge clk_sys) disable iff (srst)
    state == ASS_ARM ##1 state == ASS_CONV);
endmodule // adc_sweep_sequencer

/* File: core/ass_conv_timer.sv */
`timescale 1ns/100ps
`include "ass_params.svh"
module ass_conv_timer (
  input  wire logic clk_sys,
  input  wire logic srst,
  input  wire logic startConv,
  input  wire logic abortConv,
  output logic      convDone
);
  localparam logic [7:0] CONV_LAST = 8'(`ASS_CONV_CYC - 1);
  logic       running;
  logic [7:0] cnt;
  logic       next_running;
  logic [7:0] next_cnt;
  logic       next_convDone;

  always_comb begin
    next_running  = running;
    next_cnt      = cnt;
    next_convDone = 1'b0;
    if (abortConv) begin
      next_running = 1'b0;
      next_cnt     = 8'h00;
    end else if (startConv) begin
      next_running = 1'b1;
      next_cnt     = 8'h00;
    end else if (running) begin
      if (cnt == CONV_LAST) begin
        next_running  = 1'b0;
        next_convDone = 1'b1;
      end else begin
        next_cnt = cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      running  <= 1'b0;
      cnt      <= 8'h00;
      convDone <= 1'b0;
    end else begin
      running  <= next_running;
      cnt      <= next_cnt;
      convDone <= next_convDone;
    end
  end
endmodule // ass_conv_timer

/* File: core/ass_params.svh */
`ifndef ASS_PARAMS_SVH
`define ASS_PARAMS_SVH
// register byte offsets on the bus
`define ASS_OFF_CTRL     12'h000
`define ASS_OFF_CFG      12'h004
`define ASS_OFF_STATUS   12'h008
`define ASS_OFF_RES_BASE 12'h020
// control register fields
`define ASS_CTRL_START   0
`define ASS_CTRL_TRGSEL  1
`define ASS_CTRL_TRGSRC  2
`define ASS_CTRL_DMA     3
`define ASS_CTRL_RES10   4
// configuration register fields
`define ASS_CFG_MODE_LO  0
`define ASS_CFG_SCAN_LO  2
`define ASS_CFG_PGRP_LO  4
`define ASS_CFG_MPGRP_LO 6
// reset values
`define ASS_CTRL_RST     8'h00
`define ASS_CFG_RST      8'h00
// conversion time per channel
`define ASS_CONV_NS      1000
`define ASS_CONV_CYC     ((`ASS_CONV_NS + 9) / 10)
`endif

/* File: core/ass_pkg.sv */
package ass_pkg;
  typedef enum logic [1:0] {
    ASS_MODE_PRIO  = 2'h0,
    ASS_MODE_MSING = 2'h1,
    ASS_MODE_MREP  = 2'h2,
    ASS_MODE_RSVD  = 2'h3
  } ass_mode_t;
  typedef enum logic [2:0] {
    ASS_IDLE = 3'b001,
    ASS_ARM  = 3'b010,
    ASS_CONV = 3'b100
  } ass_state_t;
endpackage

/* File: core/ass_trig_detect.sv */
`timescale 1ns/100ps
module ass_trig_detect (
  input  wire logic clk_sys,
  input  wire logic srst,
  input  wire logic extTrigIn,
  input  wire logic timerIrq,
  input  wire logic trgSrc,
  output logic      trigPulse
);
  logic extPrev;
  logic next_extPrev;
  logic next_trigPulse;

  always_comb begin
    next_extPrev = extTrigIn;
    // falling edge of the pin, or the timer request
    next_trigPulse = trgSrc ? timerIrq : (extPrev & ~extTrigIn);
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      extPrev   <= 1'b1;
      trigPulse <= 1'b0;
    end else begin
      extPrev   <= next_extPrev;
      trigPulse <= next_trigPulse;
    end
  end
endmodule // ass_trig_detect
